// ===== hdl/dsw_event_cnt.sv
`timescale 1ns/10ps
module dsw_event_cnt #(
    parameter int         W   = 4,
    parameter logic [W-1:0] MAX = '1
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         inc_i,
    input  wire logic         clr_i,
    output logic      [W-1:0] count_o
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    wire          at_max = (count_r == MAX);

    // Clear wins over a simultaneous increment; count saturates
    assign count_nxt = clr_i ? '0 : ((inc_i && !at_max) ? count_r + 1'b1 : count_r);
    assign count_o   = count_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    AST_CNT_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clr_i |=> count_r == '0) else $error("Counter not cleared");
    AST_CNT_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        inc_i && !clr_i && !at_max |=> count_r == $past(count_r) + 1'b1)
        else $error("Counter missed an increment");
endmodule

// ===== hdl/dsw_mon_if.sv
`timescale 1ns/10ps
interface dsw_mon_if;
    logic enable;
    logic below;
    logic clear;
    logic fault;

    modport mon (
        input  enable,
        input  below,
        input  clear,
        output fault
    );

    modport ctl (
        output enable,
        output below,
        output clear,
        input  fault
    );
endinterface

// ===== hdl/dsw_pkg.sv
package dsw_pkg;
    localparam int              SW_W          = 22;
    localparam logic [SW_W-1:0] SW_RESET      = 22'h000000;
    localparam int              BIT_SUP_HIGH  = 0;
    localparam int              BIT_SUP_LOW   = 1;
    localparam int              BIT_HEAT_WARN = 2;
    localparam int              BIT_STAGE_ONE = 3;
    localparam int              BIT_STAGE_TWO = 4;
    localparam int              BIT_MAIN_REG  = 5;
    localparam int              BIT_AUX_REG   = 6;
    localparam int              BIT_PHASE_LO  = 7;
    localparam int              BIT_RETRY_LO  = 9;
    localparam int              BIT_WDC_LO    = 12;
    localparam int              BIT_KICK      = 16;
    localparam int              BIT_BUS_LOW   = 17;
    localparam int              BIT_BUS_HIGH  = 18;
    localparam int              BIT_TX_STUCK  = 19;
    localparam int              BIT_UNUSED_LO = 20;
    localparam int              PHASE_W       = 2;
    localparam int              RETRY_W       = 3;
    localparam int              WDC_W         = 4;
    localparam int              UNUSED_W      = 2;
    localparam logic [2:0]      RETRY_MAX     = 3'h7;
    localparam logic [3:0]      WDC_MAX       = 4'hf;
    localparam int              CLK_PERIOD_NS = 4;
    localparam int              FAIL_MIN_NS   = 2000;
    localparam int              FAIL_CYC      = (FAIL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int              TURN_ON_NS    = 4000000;
    localparam int              TURN_ON_CYC   = TURN_ON_NS / CLK_PERIOD_NS;
    localparam int              DOM_TOUT_NS   = 10000000;
    localparam int              DOM_TOUT_CYC  = DOM_TOUT_NS / CLK_PERIOD_NS;
    localparam int              AI_SUP_HIGH   = 0;
    localparam int              AI_SUP_LOW    = 1;
    localparam int              AI_HEAT_WARN  = 2;
    localparam int              AI_STAGE_ONE  = 3;
    localparam int              AI_STAGE_TWO  = 4;
    localparam int              AI_MAIN_LOW   = 5;
    localparam int              AI_AUX_LOW    = 6;
    localparam int              AI_BUS_LOW    = 7;
    localparam int              AI_BUS_HIGH   = 8;
    localparam int              AI_TXD        = 9;
    localparam int              AI_W          = 10;
    localparam int              REG_N         = 2;

    typedef enum logic [1:0] {
        PHASE_ACTIVE    = 2'b00,
        PHASE_MAIN_STBY = 2'b01,
        PHASE_BATT_STBY = 2'b10,
        PHASE_FLASH     = 2'b11
    } dsw_phase_t;

    typedef enum logic [1:0] {
        MON_OFF  = 2'b00,
        MON_RAMP = 2'b01,
        MON_RUN  = 2'b10
    } dsw_mon_state_t;
endpackage

// ===== hdl/dsw_reg_mon.sv
`timescale 1ns/10ps
module dsw_reg_mon #(
    parameter int RAMP_CYC = dsw_pkg::TURN_ON_CYC,
    parameter int LOW_CYC  = dsw_pkg::FAIL_CYC
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    dsw_mon_if.mon    mon
);
    import dsw_pkg::*;
    localparam int RW = $clog2(RAMP_CYC + 1);
    localparam int LW = $clog2(LOW_CYC + 2);

    dsw_mon_state_t state_r;
    dsw_mon_state_t state_nxt;
    logic [RW-1:0]  ramp_r;
    logic [LW-1:0]  low_r;
    logic [LW-1:0]  seen_r;
    logic           fault_r;

    wire ramp_done = (ramp_r == RW'(RAMP_CYC - 1));
    wire low_done  = (low_r == LW'(LOW_CYC));
    wire ramp_fail = (state_r == MON_RAMP) && ramp_done && mon.below;
    wire run_fail  = (state_r == MON_RUN) && mon.below && low_done;
    wire set_fault = ramp_fail || run_fail;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MON_OFF:  if (mon.enable) state_nxt = MON_RAMP;
            MON_RAMP: begin
                if (!mon.enable) state_nxt = MON_OFF;
                else if (ramp_done) state_nxt = MON_RUN;
            end
            MON_RUN:  if (!mon.enable) state_nxt = MON_OFF;
            default:  state_nxt = MON_OFF;
        endcase
    end

    assign mon.fault = fault_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= MON_OFF;
            ramp_r  <= '0;
            low_r   <= '0;
            fault_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ramp_r  <= (state_r == MON_RAMP) ? ramp_r + 1'b1 : '0;
            if (state_r != MON_RUN || !mon.below) low_r <= '0;
            else if (!low_done) low_r <= low_r + 1'b1;
            fault_r <= set_fault || (fault_r && !mon.clear);
        end
    end

    // Consecutive low cycles while running, for checking only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) seen_r <= '0;
        else if (state_r != MON_RUN || !mon.below) seen_r <= '0;
        else if (seen_r != LW'(LOW_CYC + 1)) seen_r <= seen_r + 1'b1;
    end

    AST_LOW_TOO_LONG: assert property (@(posedge clk_i) disable iff (!resetn_i)
        seen_r == LW'(LOW_CYC + 1) && state_r == MON_RUN |-> fault_r)
        else $error("Long low output not flagged");
    AST_RAMP_CHECK: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state_r == MON_RAMP && ramp_done && mon.below && mon.enable |=>
        fault_r && state_r == MON_RUN)
        else $error("Low output at end of turn-on not flagged");
    AST_FAULT_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        fault_r && !mon.clear |=> fault_r) else $error("Fault dropped without clear");
endmodule

// ===== hdl/dsw_status_word.sv
`timescale 1ns/10ps
// Summary of operation
// - Control register 1 access returns this word
// - Twenty-two bits, read-only, top two zero
// - Bits 0 and 1: supply high, low
// - Bit 2: warning above 130 degrees
// - Bit 3: stage one, outputs off
// - Bit 4: stage two, outputs and main regulator off
// - Bit 5: main regulator below 2V fault
// - Bit 6: auxiliary regulator below 2V fault
// - Bits 8:7 phase; main standby readout wakes
// - Bits 11:9 thermal restart failure count
// - Bits 15:12 watchdog time-out count
// - Valid kick or forced sleep clears count
// - Bit 16 echoes the kick bit
// - Bits 17-19 bus line and transmit faults
// - Guard-off bit disables transmit stuck supervision
module dsw_status_word #(
    parameter int TURN_ON_CYC  = dsw_pkg::TURN_ON_CYC,
    parameter int DOM_TOUT_CYC = dsw_pkg::DOM_TOUT_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      supply_high_i,
    input  wire logic                      supply_low_i,
    input  wire logic                      heat_warn_i,
    input  wire logic                      heat_stage_one_i,
    input  wire logic                      heat_stage_two_i,
    input  wire logic                      main_reg_low_i,
    input  wire logic                      aux_reg_low_i,
    input  wire logic                      bus_line_low_i,
    input  wire logic                      bus_line_high_i,
    input  wire logic                      txd_i,
    input  wire logic                      main_reg_on_i,
    input  wire logic                      aux_reg_on_i,
    input  dsw_pkg::dsw_phase_t            power_phase_i,
    input  wire logic                      restart_fail_i,
    input  wire logic                      restart_ok_i,
    input  wire logic                      wd_timeout_i,
    input  wire logic                      wd_valid_kick_i,
    input  wire logic                      wd_sleep_entry_i,
    input  wire logic                      kick_bit_i,
    input  wire logic                      transmit_stuck_guard_off_i,
    input  wire logic                      frame_start_i,
    input  wire logic                      frame_ctrl1_i,
    output logic      [dsw_pkg::SW_W-1:0]  status_word_o,
    output logic                           status_load_o,
    output logic                           wake_req_o,
    output logic                           outputs_off_o,
    output logic                           main_reg_off_o,
    output logic                           txd_blocked_o
);
    import dsw_pkg::*;
    localparam int TW = $clog2(DOM_TOUT_CYC + 1);

    logic [AI_W-1:0]    async_in;
    logic [AI_W-1:0]    meta_r;
    logic [AI_W-1:0]    sync_r;
    logic [REG_N-1:0]   reg_on;
    logic [REG_N-1:0]   reg_low;
    logic [REG_N-1:0]   reg_fault;
    logic [TW-1:0]      dom_cnt_r;
    logic [TW-1:0]      dom_cnt_nxt;
    logic               tx_stuck_r;
    logic               tx_stuck_nxt;
    logic [SW_W-1:0]    status_word_r;
    logic               status_load_r;
    logic               wake_req_r;
    logic               outputs_off_r;
    logic               main_reg_off_r;
    logic [RETRY_W-1:0] thermal_retry_count;
    logic [WDC_W-1:0]   watchdog_timeout_count;
    logic [SW_W-1:0]    live_word;
    dsw_phase_t         read_phase;

    // Comparator and pin inputs from outside the clock domain
    assign async_in[AI_SUP_HIGH]  = supply_high_i;
    assign async_in[AI_SUP_LOW]   = supply_low_i;
    assign async_in[AI_HEAT_WARN] = heat_warn_i;
    assign async_in[AI_STAGE_ONE] = heat_stage_one_i;
    assign async_in[AI_STAGE_TWO] = heat_stage_two_i;
    assign async_in[AI_MAIN_LOW]  = main_reg_low_i;
    assign async_in[AI_AUX_LOW]   = aux_reg_low_i;
    assign async_in[AI_BUS_LOW]   = bus_line_low_i;
    assign async_in[AI_BUS_HIGH]  = bus_line_high_i;
    assign async_in[AI_TXD]       = txd_i;

    genvar gi;
    generate
        for (gi = 0; gi < AI_W; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge resetn_i) begin
                // Transmit pin resets to recessive, its idle level
                if (!resetn_i) begin
                    meta_r[gi] <= (gi == AI_TXD);
                    sync_r[gi] <= (gi == AI_TXD);
                end else begin
                    meta_r[gi] <= async_in[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    wire supply_high_flag  = sync_r[AI_SUP_HIGH];
    wire supply_low_flag   = sync_r[AI_SUP_LOW];
    wire heat_warning_flag = sync_r[AI_HEAT_WARN];
    wire thermal_stage_one = sync_r[AI_STAGE_ONE];
    wire thermal_stage_two = sync_r[AI_STAGE_TWO];
    wire bus_line_low_fault  = sync_r[AI_BUS_LOW];
    wire bus_line_high_fault = sync_r[AI_BUS_HIGH];
    wire txd_dominant        = !sync_r[AI_TXD];
    wire kick_bit_echo       = kick_bit_i;
    wire read_req            = frame_start_i && frame_ctrl1_i;
    wire wake_on_read        = read_req && (power_phase_i == PHASE_MAIN_STBY);

    // Regulator supervision, one monitor per regulator
    assign reg_on  = {aux_reg_on_i, main_reg_on_i};
    assign reg_low = {sync_r[AI_AUX_LOW], sync_r[AI_MAIN_LOW]};

    generate
        for (gi = 0; gi < REG_N; gi++) begin : g_reg
            dsw_mon_if reg_if ();
            assign reg_if.enable = reg_on[gi];
            assign reg_if.below  = reg_low[gi];
            assign reg_if.clear  = read_req;
            assign reg_fault[gi] = reg_if.fault;
            dsw_reg_mon #(
                .RAMP_CYC (TURN_ON_CYC),
                .LOW_CYC  (FAIL_CYC)
            ) u_mon (
                .clk_i    (clk_i),
                .resetn_i (resetn_i),
                .mon      (reg_if)
            );
        end
    endgenerate

    wire main_regulator_fault = reg_fault[0];
    wire aux_regulator_fault  = reg_fault[1];

    dsw_event_cnt #(
        .W   (RETRY_W),
        .MAX (RETRY_MAX)
    ) u_retry (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .inc_i    (restart_fail_i),
        .clr_i    (restart_ok_i),
        .count_o  (thermal_retry_count)
    );

    dsw_event_cnt #(
        .W   (WDC_W),
        .MAX (WDC_MAX)
    ) u_wdc (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .inc_i    (wd_timeout_i),
        .clr_i    (wd_valid_kick_i || wd_sleep_entry_i),
        .count_o  (watchdog_timeout_count)
    );

    // Dominant transmit supervision
    wire dom_expired = (dom_cnt_r == TW'(DOM_TOUT_CYC));
    assign dom_cnt_nxt = (transmit_stuck_guard_off_i || !txd_dominant) ? '0 :
                         (dom_expired ? dom_cnt_r : dom_cnt_r + 1'b1);
    assign tx_stuck_nxt = !transmit_stuck_guard_off_i && txd_dominant &&
                          (tx_stuck_r || dom_expired);
    wire transmit_stuck_fault = tx_stuck_r;

    // A readout in main standby wakes the device, so active is reported
    assign read_phase = (power_phase_i == PHASE_MAIN_STBY) ? PHASE_ACTIVE : power_phase_i;

    assign live_word = {
        {UNUSED_W{1'b0}},
        transmit_stuck_fault,
        bus_line_high_fault,
        bus_line_low_fault,
        kick_bit_echo,
        watchdog_timeout_count,
        thermal_retry_count,
        read_phase,
        aux_regulator_fault,
        main_regulator_fault,
        thermal_stage_two,
        thermal_stage_one,
        heat_warning_flag,
        supply_low_flag,
        supply_high_flag
    };

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dom_cnt_r  <= '0;
            tx_stuck_r <= 1'b0;
        end else begin
            dom_cnt_r  <= dom_cnt_nxt;
            tx_stuck_r <= tx_stuck_nxt;
        end
    end

    // Snapshot taken once per control register 1 transfer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_word_r <= SW_RESET;
            status_load_r <= 1'b0;
            wake_req_r    <= 1'b0;
        end else begin
            if (read_req) status_word_r <= live_word;
            status_load_r <= read_req;
            wake_req_r    <= wake_on_read;
        end
    end

    // Output shutdown on thermal stages
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            outputs_off_r  <= 1'b0;
            main_reg_off_r <= 1'b0;
        end else begin
            outputs_off_r  <= thermal_stage_one || thermal_stage_two;
            main_reg_off_r <= thermal_stage_two;
        end
    end

    assign status_word_o  = status_word_r;
    assign status_load_o  = status_load_r;
    assign wake_req_o     = wake_req_r;
    assign outputs_off_o  = outputs_off_r;
    assign main_reg_off_o = main_reg_off_r;
    assign txd_blocked_o  = tx_stuck_r;

    AST_READ_SNAPSHOT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_load_o &&
        status_word_o[BIT_AUX_REG:BIT_SUP_HIGH] == $past(live_word[BIT_AUX_REG:BIT_SUP_HIGH]))
        else $error("Readout did not load the status word");
    AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
        status_word_o[SW_W-1:BIT_UNUSED_LO] == '0) else $error("Reserved bits not zero");
    AST_WORD_STABLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !read_req |=> $stable(status_word_o) && !status_load_o)
        else $error("Status word changed outside a readout");
    AST_WAKE_READ: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req && power_phase_i == PHASE_MAIN_STBY |=> wake_req_o &&
        status_word_o[BIT_PHASE_LO+:PHASE_W] == PHASE_ACTIVE)
        else $error("Standby readout did not wake");
    AST_KICK_ECHO: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_KICK] == $past(kick_bit_i))
        else $error("Kick bit not echoed");
    AST_STAGE_ONE_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
        thermal_stage_one |=> outputs_off_o) else $error("Outputs on in stage one");
    AST_STAGE_TWO_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
        thermal_stage_two |=> outputs_off_o && main_reg_off_o)
        else $error("Main regulator on in stage two");
    AST_GUARD_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
        transmit_stuck_guard_off_i |=> !txd_blocked_o)
        else $error("Transmit fault raised with guard off");
    AST_WD_FIELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wd_valid_kick_i |=> watchdog_timeout_count == '0)
        else $error("Watchdog count not cleared by kick");
    AST_FULL_SNAPSHOT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o == $past(live_word))
        else $error("Readout word differs from live fields");
    AST_REFUSED_SELECT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        frame_start_i && !frame_ctrl1_i |=> !status_load_o && $stable(status_word_o))
        else $error("Other register transfer loaded the word");
    AST_SUPPLY_FIELDS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_SUP_LOW:BIT_SUP_HIGH] ==
        $past({supply_low_flag, supply_high_flag}))
        else $error("Supply flags not captured");
    AST_HEAT_FIELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_HEAT_WARN] == $past(heat_warning_flag))
        else $error("Heat warning not captured");
    AST_STAGE_FIELDS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_STAGE_TWO:BIT_STAGE_ONE] ==
        $past({thermal_stage_two, thermal_stage_one}))
        else $error("Thermal stages not captured");
    AST_REG_FIELDS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_AUX_REG:BIT_MAIN_REG] == $past(reg_fault))
        else $error("Regulator faults not captured");
    AST_PHASE_PASS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req && power_phase_i != PHASE_MAIN_STBY |=> !wake_req_o &&
        status_word_o[BIT_PHASE_LO+:PHASE_W] == $past(power_phase_i))
        else $error("Phase field or wake wrong outside standby");
    AST_RETRY_FIELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_RETRY_LO+:RETRY_W] == $past(thermal_retry_count))
        else $error("Retry count not captured");
    AST_WD_COUNT_FIELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_WDC_LO+:WDC_W] == $past(watchdog_timeout_count))
        else $error("Watchdog count not captured");
    AST_WD_SLEEP_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wd_sleep_entry_i |=> watchdog_timeout_count == '0)
        else $error("Watchdog count not cleared by sleep entry");
    AST_BUS_FIELDS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_req |=> status_word_o[BIT_TX_STUCK:BIT_BUS_LOW] ==
        $past({tx_stuck_r, bus_line_high_fault, bus_line_low_fault}))
        else $error("Bus line flags not captured");
    AST_TX_STUCK_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !transmit_stuck_guard_off_i && txd_dominant && dom_expired |=> txd_blocked_o)
        else $error("Dominant time-out not flagged");
    AST_TX_RECESSIVE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !txd_dominant |=> !txd_blocked_o)
        else $error("Transmit fault held while recessive");
    AST_STAGE_ONE_KEEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !thermal_stage_two |=> !main_reg_off_o)
        else $error("Main regulator off without stage two");
    AST_TEMP_OK_ON: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !thermal_stage_one && !thermal_stage_two |=> !outputs_off_o)
        else $error("Outputs off without thermal stage");
endmodule

// ===== tb/diagnostic_status_word_tb_top.sv
`timescale 1ns/10ps
module diagnostic_status_word_tb_top;
    import dsw_pkg::*;
    logic            clk    = 1'b0;
    logic            resetn = 1'b0;
    logic [AI_W-1:0] ai     = 10'h200;
    logic [4:0]      pl     = 5'h00;
    logic [3:0]      lv     = 4'h0;
    dsw_phase_t      ph     = PHASE_ACTIVE;
    logic            req    = 1'b0;
    logic            sel    = 1'b0;
    logic            fs;
    logic            fc;
    logic [SW_W-1:0] word;
    logic            load;
    logic            wake;
    logic            off1;
    logic            off2;
    logic            blk;
    logic [31:0]     r;
    int              failures  = 0;
    int              cmp_count = 0;
    int              cyc       = 0;
    int              retry     = 0;
    int              wdc       = 0;
    bit              mreg      = 0;
    bit              areg      = 0;
    bit              stuck     = 0;

    always #2 clk = ~clk;

    dsw_host_model i_dsw_host_model (
        .clk_i(clk), .resetn_i(resetn), .req_i(req), .sel_i(sel),
        .frame_start_o(fs), .frame_ctrl1_o(fc)
    );

    dsw_status_word #(.TURN_ON_CYC(20), .DOM_TOUT_CYC(30)) i_dsw_status_word (
        .clk_i(clk), .resetn_i(resetn),
        .supply_high_i(ai[AI_SUP_HIGH]), .supply_low_i(ai[AI_SUP_LOW]),
        .heat_warn_i(ai[AI_HEAT_WARN]), .heat_stage_one_i(ai[AI_STAGE_ONE]),
        .heat_stage_two_i(ai[AI_STAGE_TWO]), .main_reg_low_i(ai[AI_MAIN_LOW]),
        .aux_reg_low_i(ai[AI_AUX_LOW]), .bus_line_low_i(ai[AI_BUS_LOW]),
        .bus_line_high_i(ai[AI_BUS_HIGH]), .txd_i(ai[AI_TXD]),
        .main_reg_on_i(lv[2]), .aux_reg_on_i(lv[3]), .power_phase_i(ph),
        .restart_fail_i(pl[0]), .restart_ok_i(pl[1]), .wd_timeout_i(pl[2]),
        .wd_valid_kick_i(pl[3]), .wd_sleep_entry_i(pl[4]), .kick_bit_i(lv[0]),
        .transmit_stuck_guard_off_i(lv[1]), .frame_start_i(fs), .frame_ctrl1_i(fc),
        .status_word_o(word), .status_load_o(load), .wake_req_o(wake),
        .outputs_off_o(off1), .main_reg_off_o(off2), .txd_blocked_o(blk)
    );

    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Reference word built from the driven inputs and the bench counters
    function automatic logic [SW_W-1:0] exp_word();
        logic [SW_W-1:0] w;
        w               = '0;
        w[4:0]          = ai[4:0];
        w[BIT_MAIN_REG] = mreg;
        w[BIT_AUX_REG]  = areg;
        w[8:7]          = (ph == PHASE_MAIN_STBY) ? 2'b00 : ph;
        w[11:9]         = retry[2:0];
        w[15:12]        = wdc[3:0];
        w[BIT_KICK]     = lv[0];
        w[BIT_BUS_LOW]  = ai[AI_BUS_LOW];
        w[BIT_BUS_HIGH] = ai[AI_BUS_HIGH];
        w[BIT_TX_STUCK] = stuck;
        return w;
    endfunction

    // One transfer; a non-matching select must leave the word alone
    task automatic readout(input bit s);
        logic [SW_W-1:0] e;
        e = s ? exp_word() : word;
        @(posedge clk);
        req <= 1'b1;
        sel <= s;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
        chk(word, e);
        chk(load, s);
        chk(wake, s && ph == PHASE_MAIN_STBY);
        if (s) begin
            mreg = 0;
            areg = 0;
        end
    endtask

    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            pl[k] <= 1'b1;
            @(posedge clk);
            pl[k] <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            $display("ERROR %0t run did not finish", $time);
            results();
        end
    end

    initial begin
        void'($urandom(32'h117e536c));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        readout(1);
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            @(posedge clk);
            ai <= {1'b1, r[8:7], 2'b00, r[4:0]};
            ph <= dsw_phase_t'(i % 4);
            lv[0] <= r[9];
            repeat (5) @(posedge clk);
            #1;
            chk(off1, ai[AI_STAGE_ONE] | ai[AI_STAGE_TWO]);
            chk(off2, ai[AI_STAGE_TWO]);
            readout(1);
            readout(r[10]);
        end
        @(posedge clk);
        ai <= 10'h200;
        ph <= PHASE_ACTIVE;
        lv[0] <= 1'b0;
        pulse(0, 9);
        retry = 7;
        readout(1);
        pulse(1, 1);
        retry = 0;
        readout(1);
        pulse(2, 17);
        wdc = 15;
        readout(1);
        pulse(3, 1);
        wdc = 0;
        readout(1);
        pulse(2, 3);
        wdc = 3;
        readout(1);
        pulse(4, 1);
        wdc = 0;
        readout(1);
        @(posedge clk);
        ai[6:5] <= 2'b11;
        lv[3:2] <= 2'b11;
        repeat (30) @(posedge clk);
        mreg = 1;
        areg = 1;
        readout(1);
        @(posedge clk);
        ai[6:5] <= 2'b00;
        repeat (4) @(posedge clk);
        readout(1);
        @(posedge clk);
        ai[6:5] <= 2'b11;
        repeat (520) @(posedge clk);
        ai[6:5] <= 2'b00;
        repeat (4) @(posedge clk);
        mreg = 1;
        areg = 1;
        readout(1);
        @(posedge clk);
        ai[AI_TXD] <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
        chk(blk, 1);
        stuck = 1;
        readout(1);
        @(posedge clk);
        lv[1] <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(blk, 0);
        stuck = 0;
        readout(1);
        results();
    end
endmodule

// ===== tb/dsw_host_model.sv
`timescale 1ns/10ps
// Serial master: one start pulse per request, register select valid with it
module dsw_host_model (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic req_i,
    input  wire logic sel_i,
    output logic      frame_start_o,
    output logic      frame_ctrl1_o
);
    // Select toggles outside a transfer so stale values are never trusted
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_start_o <= 1'b0;
            frame_ctrl1_o <= 1'b0;
        end else begin
            frame_start_o <= req_i;
            frame_ctrl1_o <= req_i ? sel_i : ~frame_ctrl1_o;
        end
    end
endmodule
